/* src/bioc_top.sv */
`timescale 1ns/1ns
// Contract
// - Control command with c in 8-F loads c low three bits into mode.
// - Mode comes from command bits 6..4; besides reset to idle, nothing else loads or clears it.
// - c equal to 1000 clears the mode to idle.
// - Mode top bit set routes the input bus in place of file data.
// - External I/O command moves file or input bus data to destination.
// - Eight modes decode to idle, three outputs, four inputs strobes.
// - 1001 control output, 1010 data output, 1011 serial space.
// - C concurrent ack, D interrupt ack, E data input, F spare.
// - Serial output spaces only in serial space mode, else marks.
// - c codes 0,1,2,4,7 leave the mode register alone.
// - Any internal status bit set raises file zero bit 4.
// - Enter internal status moves the status byte to the file.
// - Status bits: 0 console, 1 DMA, 2 clock, 4 parity, 6 halt, 7 power.
// - Input data feeds B bus; input control lines sit in file zero.
// - Input bus lines are active low and are inverted on entry.
// - Each I/O step, load or clear included, takes one machine cycle.
// - File zero: external interrupt bit 7, reply 5, transfer request 3.
// - Serial receive is file zero bit 6, one while a space arrives.
module bioc_top
    import bioc_pkg::*;
(
    input  wire logic          ref_clk_i,
    input  wire logic          rst_n_i,
    // Control micro-command, one per step
    input  wire logic          cmd_valid_i,
    input  wire logic [15:0]   cmd_i,
    input  wire logic [7:0]    file_data_i,
    input  wire logic [7:0]    sense_sw_i,
    input  wire logic [7:0]    console_sw_i,
    // Shared input bus and lines, active low except serial_rx_space_i
    input  wire logic [7:0]    in_data_n_i,
    input  wire logic          ext_int_n_i,
    input  wire logic          io_reply_n_i,
    input  wire logic          conc_req_n_i,
    input  wire logic          serial_rx_space_i,
    // Internal status sources
    input  wire logic          console_int_i,
    input  wire logic          dma_int_i,
    input  wire logic          rt_clock_int_i,
    input  wire logic          parity_err_i,
    input  wire logic          halt_sw_i,
    input  wire logic          power_fail_i,
    input  wire logic [1:0]    spare_status_i,
    // Outputs, and the xfer_ready_i handshake input
    output logic               cmd_ready_o,
    output logic [2:0]         io_bus_mode_o,
    output bioc_strobes_s      strobes_o,
    output logic               serial_tx_mark_o,
    output logic               input_flag_o,
    output logic [7:0]         file0_flags_o,
    output logic [7:0]         internal_status_bits_o,
    output logic               xfer_valid_o,
    input  wire logic          xfer_ready_i,
    output bioc_xfer_s         xfer_o
);

    function automatic bioc_strobes_s decode_mode(input logic [2:0] m);
        bioc_strobes_s s;
        s = '0;
        case (m)
            MODE_IDLE:     s = '0;
            MODE_CTRL_OUT: s.ctrl_out_strobe    = 1'b1;
            MODE_DATA_OUT: s.data_output_strobe = 1'b1;
            MODE_SPACE:    s.serial_space       = 1'b1;
            MODE_CONC_ACK: s.concurrent_ack     = 1'b1;
            MODE_INTR_ACK: s.interrupt_ack      = 1'b1;
            MODE_DATA_IN:  s.data_input_strobe  = 1'b1;
            MODE_SPARE:    s.spare_mode         = 1'b1;
            default:       s = '0;
        endcase
        return s;
    endfunction

    logic [2:0]    io_bus_mode_r;
    logic [2:0]    io_bus_mode_nxt;
    bioc_strobes_s strobes_r;
    logic          serial_tx_mark_r;
    logic [7:0]    status_r;
    logic [7:0]    file0_r;
    logic [3:0]    opc;
    logic [3:0]    cfld;
    logic [3:0]    fsel;
    logic          is_ctrl;
    logic          is_io;
    logic          take;
    logic          fifo_ready;
    logic [7:0]    in_bus;
    logic [7:0]    xfer_byte;
    logic          xfer_push;
    logic [FIFO_WIDTH-1:0] fifo_out;

    assign opc     = cmd_i[OPC_LSB +: 4];
    assign fsel    = cmd_i[FILE_LSB +: 4];
    assign cfld    = cmd_i[CFLD_LSB +: 4];
    assign is_ctrl = (opc == OPC_CONTROL);
    assign is_io   = cfld[3];
    // Stall the command stream while the transfer queue is full
    assign take        = cmd_valid_i && fifo_ready;
    assign cmd_ready_o = fifo_ready;

    assign in_bus = ~in_data_n_i;

    // Mode register: only external I/O control commands touch it
    always_comb
    begin
        io_bus_mode_nxt = io_bus_mode_r;
        if (take && is_ctrl && is_io)
        begin
            io_bus_mode_nxt = cfld[2:0];
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            io_bus_mode_r <= MODE_RESET;
        end
        else
        begin
            io_bus_mode_r <= io_bus_mode_nxt;
        end
    end

    // Strobes registered from the next mode so they track the mode exactly
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            strobes_r        <= '0;
            serial_tx_mark_r <= 1'b1;
        end
        else
        begin
            strobes_r        <= decode_mode(io_bus_mode_nxt);
            serial_tx_mark_r <= (io_bus_mode_nxt != MODE_SPACE);
        end
    end

    // Internal status sampled every cycle
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            status_r <= BYTE_RESET;
        end
        else
        begin
            status_r[IS_CONSOLE_INT] <= console_int_i;
            status_r[IS_DMA]         <= dma_int_i;
            status_r[IS_RT_CLOCK]    <= rt_clock_int_i;
            status_r[3]              <= spare_status_i[0];
            status_r[IS_PARITY]      <= parity_err_i;
            status_r[5]              <= spare_status_i[1];
            status_r[IS_HALT_SW]     <= halt_sw_i;
            status_r[IS_POWER_FAIL]  <= power_fail_i;
        end
    end

    // File zero flag byte; arithmetic flags 0..2 live elsewhere
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            file0_r <= BYTE_RESET;
        end
        else
        begin
            file0_r              <= BYTE_RESET;
            file0_r[F0_CONC_REQ] <= ~conc_req_n_i;
            file0_r[F0_INT_INT]  <= |status_r;
            file0_r[F0_REPLY]    <= ~io_reply_n_i;
            file0_r[F0_SERIAL_IN] <= serial_rx_space_i;
            file0_r[F0_EXT_INT]  <= ~ext_int_n_i;
        end
    end

    // Data source for the transfer of this command
    always_comb
    begin
        xfer_byte = file_data_i;
        xfer_push = 1'b0;
        if (take && is_ctrl)
        begin
            if (is_io)
            begin
                xfer_push = 1'b1;
                // Source follows the mode in force at this command
                xfer_byte = io_bus_mode_r[2] ? in_bus : file_data_i;
            end
            else
            begin
                case (cfld)
                    C_SENSE_SW:
                    begin
                        xfer_push = 1'b1;
                        xfer_byte = sense_sw_i;
                    end
                    C_SHIFT_R4:
                    begin
                        xfer_push = 1'b1;
                        xfer_byte = {4'h0, file_data_i[7:4]};
                    end
                    C_INT_STATUS:
                    begin
                        xfer_push = 1'b1;
                        xfer_byte = status_r;
                    end
                    C_CONSOLE_SW:
                    begin
                        xfer_push = 1'b1;
                        xfer_byte = console_sw_i;
                    end
                    default:
                    begin
                        xfer_push = 1'b0;
                        xfer_byte = file_data_i;
                    end
                endcase
            end
        end
    end

    bioc_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk_i   (ref_clk_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (xfer_push),
        .in_ready_o  (fifo_ready),
        .in_data_i   ({fsel, xfer_byte}),
        .out_valid_o (xfer_valid_o),
        .out_ready_i (xfer_ready_i),
        .out_data_o  (fifo_out)
    );

    assign xfer_o                 = bioc_xfer_s'(fifo_out);
    assign io_bus_mode_o          = io_bus_mode_r;
    assign strobes_o              = strobes_r;
    assign serial_tx_mark_o       = serial_tx_mark_r;
    assign input_flag_o           = io_bus_mode_r[2];
    assign file0_flags_o          = file0_r;
    assign internal_status_bits_o = status_r;

endmodule

/* shared/bioc_pkg.sv */
package bioc_pkg;

    // Control micro-command layout
    localparam int OPC_LSB    = 12;
    localparam int FILE_LSB   = 8;
    localparam int CFLD_LSB   = 4;
    localparam int STAR_BIT   = 3;
    localparam logic [3:0] OPC_CONTROL = 4'h7;

    // c field codes that do not touch the mode register
    localparam logic [3:0] C_NOP          = 4'h0;
    localparam logic [3:0] C_SENSE_SW     = 4'h1;
    localparam logic [3:0] C_SHIFT_R4     = 4'h2;
    localparam logic [3:0] C_INT_STATUS   = 4'h4;
    localparam logic [3:0] C_CONSOLE_SW   = 4'h7;

    // Mode register encodings
    typedef enum logic [2:0] {
        MODE_IDLE      = 3'b000,
        MODE_CTRL_OUT  = 3'b001,
        MODE_DATA_OUT  = 3'b010,
        MODE_SPACE     = 3'b011,
        MODE_CONC_ACK  = 3'b100,
        MODE_INTR_ACK  = 3'b101,
        MODE_DATA_IN   = 3'b110,
        MODE_SPARE     = 3'b111
    } bioc_mode_e;

    localparam logic [2:0] MODE_RESET = 3'h0;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    // File register zero flag positions
    localparam int F0_CONC_REQ  = 3;
    localparam int F0_INT_INT   = 4;
    localparam int F0_REPLY     = 5;
    localparam int F0_SERIAL_IN = 6;
    localparam int F0_EXT_INT   = 7;

    // Internal status bit positions
    localparam int IS_CONSOLE_INT = 0;
    localparam int IS_DMA         = 1;
    localparam int IS_RT_CLOCK    = 2;
    localparam int IS_PARITY      = 4;
    localparam int IS_HALT_SW     = 6;
    localparam int IS_POWER_FAIL  = 7;

    localparam int FIFO_WIDTH = 12;
    localparam int FIFO_DEPTH = 8;

    localparam int STEP_NS   = 220;
    localparam int CLK_NS    = 100;
    localparam int STEP_CYC  = (STEP_NS + CLK_NS - 1) / CLK_NS;

    typedef struct packed {
        logic ctrl_out_strobe;
        logic data_output_strobe;
        logic serial_space;
        logic concurrent_ack;
        logic interrupt_ack;
        logic data_input_strobe;
        logic spare_mode;
    } bioc_strobes_s;

    // Transfer result: destination file number and byte
    typedef struct packed {
        logic [3:0] file_sel;
        logic [7:0] data;
    } bioc_xfer_s;

endpackage

/* src/bioc_fifo.sv */
`timescale 1ns/1ns
module bioc_fifo
    import bioc_pkg::*;
#(
    parameter int WIDTH = 12,
    parameter int DEPTH = 8
)(
    input  wire logic             ref_clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      count_r;
    logic             push;
    logic             pop;

    assign in_ready_o  = (count_r != (AW+1)'(DEPTH));
    assign out_valid_o = (count_r != '0);
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;
    assign out_data_o  = mem_r[rd_ptr_r];

    always_ff @(posedge ref_clk_i)
    begin
        if (push)
        begin
            mem_r[wr_ptr_r] <= in_data_i;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
            end
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

endmodule

/* dv/bioc_checker.sv */
`timescale 1ns/1ns
module bioc_checker
    import bioc_pkg::*;
(
    input wire logic          ref_clk_i,
    input wire logic          rst_n_i,
    input wire logic          cmd_valid_i,
    input wire logic [15:0]   cmd_i,
    input wire logic          ext_int_n_i,
    input wire logic          io_reply_n_i,
    input wire logic          conc_req_n_i,
    input wire logic          serial_rx_space_i,
    input wire logic          cmd_ready_o,
    input wire logic [2:0]    io_bus_mode_o,
    input wire bioc_strobes_s strobes_o,
    input wire logic          serial_tx_mark_o,
    input wire logic          input_flag_o,
    input wire logic [7:0]    file0_flags_o,
    input wire logic [7:0]    internal_status_bits_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    logic take;
    assign take = cmd_valid_i && cmd_ready_o && cmd_i[15:12] == OPC_CONTROL;
    sequence s_set;
        take && cmd_i[7];
    endsequence
    sequence s_idle;
        io_bus_mode_o == MODE_IDLE && strobes_o == 7'h00;
    endsequence
    property p_load;
        s_set |=> io_bus_mode_o == $past(cmd_i[6:4]);
    endproperty
    a_load: assert property (p_load)
        else $error("mode not loaded from command");
    property p_clear;
        take && cmd_i[7:4] == 4'h8 |=> s_idle;
    endproperty
    a_clear: assert property (p_clear)
        else $error("clear command left a mode");
    property p_keep;
        !(take && cmd_i[7]) |=> $stable(io_bus_mode_o) && $stable(strobes_o);
    endproperty
    a_keep: assert property (p_keep)
        else $error("mode changed without a load");
    property p_decode;
        strobes_o == {io_bus_mode_o == 3'h1, io_bus_mode_o == 3'h2,
            io_bus_mode_o == 3'h3, io_bus_mode_o == 3'h4,
            io_bus_mode_o == 3'h5, io_bus_mode_o == 3'h6,
            io_bus_mode_o == 3'h7};
    endproperty
    a_decode: assert property (p_decode)
        else $error("strobes do not match mode");
    property p_mark;
        serial_tx_mark_o == (io_bus_mode_o != MODE_SPACE);
    endproperty
    a_mark: assert property (p_mark)
        else $error("serial output level wrong");
    property p_flag;
        input_flag_o == io_bus_mode_o[2];
    endproperty
    a_flag: assert property (p_flag)
        else $error("input flag wrong");
    property p_lines;
        $past(rst_n_i) |-> file0_flags_o[7:5] == {~$past(ext_int_n_i),
            $past(serial_rx_space_i), ~$past(io_reply_n_i)}
            && file0_flags_o[3] == ~$past(conc_req_n_i)
            && file0_flags_o[2:0] == 3'h0;
    endproperty
    a_lines: assert property (p_lines)
        else $error("file zero line flags wrong");
    property p_int;
        $past(rst_n_i) |-> file0_flags_o[4] == |$past(internal_status_bits_o);
    endproperty
    a_int: assert property (p_int)
        else $error("internal interrupt flag wrong");
endmodule

bind bioc_top bioc_checker i_bioc_checker (.ref_clk_i, .rst_n_i,
    .cmd_valid_i, .cmd_i, .ext_int_n_i, .io_reply_n_i, .conc_req_n_i,
    .serial_rx_space_i, .cmd_ready_o, .io_bus_mode_o, .strobes_o,
    .serial_tx_mark_o, .input_flag_o, .file0_flags_o,
    .internal_status_bits_o);

/* dv/bioc_periph.sv */
`timescale 1ns/1ns
module bioc_periph
    import bioc_pkg::*;
(
    input  wire logic          ref_clk_i,
    input  wire logic          rst_n_i,
    input  wire bioc_strobes_s strobes_i,
    input  wire logic          mark_i,
    input  wire logic [7:0]    byte_i,
    input  wire logic          int_req_i,
    output logic [7:0]         in_data_n_o,
    output logic               ext_int_n_o,
    output logic               io_reply_n_o,
    output logic               conc_req_n_o,
    output logic               rx_space_o
);
    logic int_r;
    logic conc_r;
    // Released bus floats to the pull-up, which reads as zero
    assign in_data_n_o = strobes_i.data_input_strobe ? ~byte_i : 8'hFF;
    assign ext_int_n_o = ~int_r;
    assign conc_req_n_o = ~conc_r;
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            int_r <= 1'b0;
            conc_r <= 1'b0;
            io_reply_n_o <= 1'b1;
            rx_space_o <= 1'b0;
        end
        else
        begin
            int_r <= int_req_i | (int_r & ~strobes_i.interrupt_ack);
            conc_r <= strobes_i.data_output_strobe
                | (conc_r & ~strobes_i.concurrent_ack);
            io_reply_n_o <= ~(strobes_i.ctrl_out_strobe
                | strobes_i.data_input_strobe);
            // Terminal echoes what it hears, one cycle late
            rx_space_o <= ~mark_i;
        end
    end
endmodule

/* dv/testbench.sv */
`timescale 1ns/1ns
module testbench;
    import bioc_pkg::*;
    logic          ref_clk_i = 1'b0;
    logic          rst_n_i = 1'b0;
    logic          cmd_valid_i = 1'b0;
    logic          xfer_ready_i = 1'b0;
    logic          int_req = 1'b0;
    logic [15:0]   cmd_i = 16'h0000;
    logic [7:0]    file_data_i = 8'hA5;
    logic [7:0]    sense_sw_i = 8'h3C;
    logic [7:0]    console_sw_i = 8'hC3;
    logic [7:0]    st = 8'h00;
    logic [7:0]    pbyte = 8'h5A;
    wire [7:0]     in_data_n_i;
    wire           ext_int_n_i, io_reply_n_i, conc_req_n_i, serial_rx_space_i;
    wire           cmd_ready_o, serial_tx_mark_o, input_flag_o, xfer_valid_o;
    wire [2:0]     io_bus_mode_o;
    wire [7:0]     file0_flags_o, internal_status_bits_o;
    wire bioc_strobes_s strobes_o;
    wire bioc_xfer_s    xfer_o;
    int            fails = 0;
    int            n_compared = 0;

    always #50 ref_clk_i = ~ref_clk_i;

    bioc_top i_bioc_top (.ref_clk_i, .rst_n_i, .cmd_valid_i, .cmd_i,
        .file_data_i, .sense_sw_i, .console_sw_i, .in_data_n_i,
        .ext_int_n_i, .io_reply_n_i, .conc_req_n_i, .serial_rx_space_i,
        .console_int_i(st[0]), .dma_int_i(st[1]), .rt_clock_int_i(st[2]),
        .parity_err_i(st[4]), .halt_sw_i(st[6]), .power_fail_i(st[7]),
        .spare_status_i({st[5], st[3]}), .cmd_ready_o, .io_bus_mode_o,
        .strobes_o, .serial_tx_mark_o, .input_flag_o, .file0_flags_o,
        .internal_status_bits_o, .xfer_valid_o, .xfer_ready_i, .xfer_o);
    bioc_periph i_bioc_periph (.ref_clk_i, .rst_n_i,
        .strobes_i(strobes_o), .mark_i(serial_tx_mark_o), .byte_i(pbyte),
        .int_req_i(int_req), .in_data_n_o(in_data_n_i),
        .ext_int_n_o(ext_int_n_i), .io_reply_n_o(io_reply_n_i),
        .conc_req_n_o(conc_req_n_i), .rx_space_o(serial_rx_space_i));

    task automatic print_verdict();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk_i) #5;
    endtask
    function automatic logic [15:0] k(input logic [3:0] c);
        return {OPC_CONTROL, 4'h3, c, 4'h0};
    endfunction
    // Hold keeps valid up so the next command goes back to back
    task automatic send(input logic [15:0] w, input bit hold);
        cmd_i = w;
        cmd_valid_i = 1'b1;
        for (int n = 0; n < 50 && cmd_ready_o !== 1'b1; n++) step(1);
        check(cmd_ready_o, 1'b1);
        step(1);
        if (!hold)
            cmd_valid_i = 1'b0;
        if (!hold)
            step(1);
    endtask
    task automatic pop(input logic [11:0] exp);
        for (int n = 0; n < 20 && xfer_valid_o !== 1'b1; n++) step(1);
        check(xfer_valid_o, 1'b1);
        check(xfer_o, exp);
        xfer_ready_i = 1'b1;
        step(1);
        xfer_ready_i = 1'b0;
        step(1);
    endtask

    task automatic t_modes();
        logic [2:0] m;
        for (int c = 9; c < 16; c++)
        begin
            m = c[2:0];
            send(k(c[3:0]), 1'b0);
            check(io_bus_mode_o, m);
            check(strobes_o, 7'h40 >> (m - 3'h1));
            check(serial_tx_mark_o, m != 3'h3);
            check(input_flag_o, m[2]);
            pop({4'h3, file_data_i});
            check(file0_flags_o[6], m == 3'h3);
            // Partner raises reply in modes 1 and 6
            check(file0_flags_o[5], m == 3'h1 || m == 3'h6);
            // Request set by data output, dropped by concurrent ack
            check(file0_flags_o[3], m == 3'h2 || m == 3'h3);
            send(k(4'h8), 1'b0);
            check(io_bus_mode_o, 3'h0);
            pop({4'h3, m == 3'h6 ? pbyte :
                m[2] ? 8'h00 : file_data_i});
        end
        $display("mode test done");
    endtask
    task automatic t_status();
        st = 8'h10;
        step(3);
        check(internal_status_bits_o, 8'h10);
        check(file0_flags_o[4], 1'b1);
        send(k(4'h4), 1'b0);
        pop({4'h3, 8'h10});
        st = 8'hFF;
        step(3);
        check(internal_status_bits_o, 8'hFF);
        st = 8'h00;
        step(3);
        check(file0_flags_o[4], 1'b0);
        int_req = 1'b1;
        step(1);
        int_req = 1'b0;
        step(2);
        check(file0_flags_o[7], 1'b1);
        send(k(4'hD), 1'b0);
        send(k(4'h8), 1'b0);
        check(file0_flags_o[7], 1'b0);
        pop({4'h3, file_data_i});
        pop({4'h3, 8'h00});
        $display("status test done");
    endtask
    task automatic t_fifo();
        for (int i = 0; i < FIFO_DEPTH; i++) send(k(4'h1), 1'b1);
        step(2);
        check(cmd_ready_o, 1'b0);
        cmd_valid_i = 1'b0;
        for (int i = 0; i < FIFO_DEPTH; i++) pop({4'h3, sense_sw_i});
        check(xfer_valid_o, 1'b0);
        check(cmd_ready_o, 1'b1);
        $display("buffer test done");
    endtask
    task automatic t_keep();
        logic [3:0] code [4];
        logic [7:0] src [4];
        code = '{4'h1, 4'h2, 4'h4, 4'h7};
        src = '{sense_sw_i, file_data_i >> 4, st, console_sw_i};
        send(k(4'hA), 1'b0);
        pop({4'h3, file_data_i});
        for (int i = 0; i < 4; i++)
        begin
            send(k(code[i]), 1'b0);
            check(io_bus_mode_o, 3'h2);
            pop({4'h3, src[i]});
        end
        send(16'h8390, 1'b0);
        send(k(4'h3), 1'b0);
        send(k(4'h0), 1'b0);
        check(io_bus_mode_o, 3'h2);
        $display("hold test done");
    endtask
    // Reset in mid-run while a space is keyed and words are queued
    task automatic t_reset();
        send(k(4'h8), 1'b0);
        send(k(4'hB), 1'b0);
        send(k(4'h1), 1'b0);
        rst_n_i = 1'b0;
        step(1);
        check(io_bus_mode_o, 3'h0);
        check(strobes_o, 7'h00);
        check(serial_tx_mark_o, 1'b1);
        check(file0_flags_o, 8'h00);
        check(xfer_valid_o, 1'b0);
        check(cmd_ready_o, 1'b1);
        rst_n_i = 1'b1;
        send(k(4'h9), 1'b0);
        check(io_bus_mode_o, 3'h1);
        check(strobes_o, 7'h40);
        pop({4'h3, file_data_i});
        send(k(4'h8), 1'b0);
        pop({4'h3, file_data_i});
        $display("reset test done");
    endtask

    initial
    begin
        repeat (8) @(posedge ref_clk_i);
        #5;
        rst_n_i = 1'b1;
        t_modes();
        t_status();
        t_fifo();
        t_keep();
        t_reset();
        print_verdict();
    end
    // Whole run needs well under a thousand cycles
    initial
    begin
        #(3000 * CLK_NS);
        fails++;
        print_verdict();
    end
endmodule
